// >>> bench/asi_master_model.sv
// bus master model issuing basic data calls
`timescale 1ns/1ps
module asi_master_model (
  // clock
  input wire logic sys_clk_in,
  // data call and reply
  output logic call_stb_out,
  output logic [3:0] call_out,
  input wire logic [3:0] reply_in,
  input wire logic reply_vld_in
);
  // idle call lines
  initial begin
    call_stb_out = 1'b0;
    call_out = 4'hF;
  end
  // one call per strobe; the reply is read just after the edge that takes the call
  task automatic do_call(input logic [3:0] c, output logic vld, output logic [3:0] rep);
    @(posedge sys_clk_in);
    #1;
    call_stb_out = 1'b1;
    call_out = c;
    @(posedge sys_clk_in);
    #1;
    call_stb_out = 1'b0;
    call_out = ~c; // released lines must not keep the old number
    vld = reply_vld_in;
    rep = reply_in;
  endtask
endmodule

// >>> bench/svc_ctrl_checker.sv
// assertions on the ports of the service control logic
`timescale 1ns/1ps
module svc_ctrl_checker
  import svc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // watched inputs
  input wire logic cfg_valid_in,
  input wire logic dl_stb_in,
  input wire logic [7:0] dl_data_in,
  input wire logic stop_req_in,
  input wire logic pwd_chg_stb_in,
  input wire logic [4:0] slave_addr_in,
  input wire logic call_stb_in,
  input wire logic [3:0] call_in,
  // watched outputs
  input wire logic [3:0] reply_out,
  input wire logic reply_vld_out,
  input wire logic oc_enable_out,
  input wire logic [3:0] leds_out,
  input wire logic err_mem_we_out,
  input wire logic code_we_out,
  input wire logic dl_req_out,
  input wire logic cfg_we_out,
  input wire logic [7:0] cfg_data_out,
  input wire logic master_access_out,
  input wire logic stop_out,
  input wire logic pwd_we_out
);
  // ****************************************************
  // sequences
  // ****************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_dl_take;
    dl_stb_in && dl_req_out && !cfg_valid_in;
  endsequence
  sequence s_dl_write;
    cfg_we_out && (cfg_data_out == $past(dl_data_in));
  endsequence
  sequence s_call_take;
    call_stb_in && (slave_addr_in != NO_ADDR) && (call_in[3:1] == 3'h0);
  endsequence
  // ****************************************************
  // assertions
  // ****************************************************
  addr_gate_a: assert property (call_stb_in && slave_addr_in == NO_ADDR |=> !reply_vld_out)
    else $error("reply without own bus address");
  call_reply_a: assert property (s_call_take |=> reply_vld_out)
    else $error("basic data call not answered");
  odd_flag_a: assert property (reply_vld_out |-> reply_out[3] == $past(call_in[0]))
    else $error("top reply bit does not follow call parity");
  press_flash_a: assert property (err_mem_we_out |-> leds_out == LEDS_ALL && !oc_enable_out)
    else $error("press without flash or with outputs on");
  dl_copy_a: assert property (s_dl_take |=> s_dl_write)
    else $error("download byte not written");
  code_return_a: assert property (code_we_out |=> oc_enable_out)
    else $error("no return to protection after code store");
  stop_grant_a: assert property (master_access_out && stop_req_in |=> stop_out)
    else $error("stop not granted under master access");
  pwd_store_a: assert property (pwd_chg_stb_in && master_access_out |=> pwd_we_out)
    else $error("password store not issued");
endmodule
bind svc_ctrl svc_ctrl_checker chk (
  .sys_clk_in, .resetn_in, .cfg_valid_in, .dl_stb_in, .dl_data_in, .stop_req_in,
  .pwd_chg_stb_in, .slave_addr_in, .call_stb_in, .call_in, .reply_out, .reply_vld_out,
  .oc_enable_out, .leds_out, .err_mem_we_out, .code_we_out, .dl_req_out, .cfg_we_out,
  .cfg_data_out, .master_access_out, .stop_out, .pwd_we_out
);

// >>> bench/tb.sv
// self-checking bench for the service control logic
`timescale 1ns/1ps
module tb;
  import svc_pkg::*;
  // ****************************************************
  // signals
  // ****************************************************
  localparam int DB = 4;
  localparam int FL = 8;
  localparam int RF = 16;
  logic sys_clk_in, resetn_in, service_btn_in, fw_new_mode_in, cfg_valid_in, code_stb_in;
  logic others_sending_in, fatal_err_in, oc1_off_in, oc2_off_in, dl_present_in, dl_stb_in;
  logic dl_last_in, pwd_stb_in, stop_req_in, pwd_chg_stb_in, call_stb_in, reply_vld_out;
  logic oc_enable_out, auto_addr_en_out, err_mem_we_out, err_one_missing_out, code_we_out;
  logic dl_req_out, cfg_we_out, restart_out, access_out, master_access_out, stop_out;
  logic pwd_we_out, p_flash, vld, got;
  logic [5:0] missing_cnt_in;
  logic [31:0] code_in, code_out;
  logic [7:0] dl_data_in, cfg_data_out;
  logic [39:0] pwd_in, user_pwd_in;
  logic [15:0] dl_code_in;
  logic [4:0] slave_addr_in;
  logic [3:0] call_in, reply_out, leds_out, rep, p_err, p_code, p_rst;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  typedef struct packed {logic [4:0] a; logic [3:0] c; logic o1; logic o2; logic v;
    logic [3:0] r;} row_t;
  // address, call, output circuit states, expected valid and reply
  row_t rows [9] = '{'{5'h03, 4'h0, 1'b0, 1'b0, 1'b1, 4'h0}, '{5'h03, 4'h1, 1'b0, 1'b0, 1'b1, 4'h8},
    '{5'h00, 4'h0, 1'b0, 1'b0, 1'b0, 4'h0}, '{5'h03, 4'h0, 1'b1, 1'b0, 1'b1, 4'h1},
    '{5'h03, 4'h1, 1'b1, 1'b0, 1'b1, 4'h9}, '{5'h03, 4'h2, 1'b1, 1'b0, 1'b0, 4'h0},
    '{5'h03, 4'h1, 1'b0, 1'b1, 1'b1, 4'h9}, '{5'h03, 4'h0, 1'b0, 1'b1, 1'b1, 4'h2},
    '{5'h03, 4'h1, 1'b0, 1'b1, 1'b1, 4'hA}};
  svc_ctrl #(.DEBOUNCE_CYC_P(DB), .LED_FLASH_CYC_P(FL), .REFRESH_CYC_P(RF)) DUT (
    .sys_clk_in, .resetn_in, .service_btn_in, .fw_new_mode_in, .cfg_valid_in, .missing_cnt_in,
    .code_stb_in, .code_in, .others_sending_in, .fatal_err_in, .oc1_off_in, .oc2_off_in,
    .dl_present_in, .dl_stb_in, .dl_data_in, .dl_last_in, .pwd_stb_in, .pwd_in, .user_pwd_in,
    .dl_code_in, .stop_req_in, .pwd_chg_stb_in, .slave_addr_in, .call_stb_in, .call_in,
    .reply_out, .reply_vld_out, .oc_enable_out, .leds_out, .auto_addr_en_out, .err_mem_we_out,
    .err_one_missing_out, .code_we_out, .code_out, .dl_req_out, .cfg_we_out, .cfg_data_out,
    .restart_out, .access_out, .master_access_out, .stop_out, .pwd_we_out);
  asi_master_model master (.sys_clk_in, .call_stb_out(call_stb_in), .call_out(call_in),
    .reply_in(reply_out), .reply_vld_in(reply_vld_out));
  // ****************************************************
  // clock, timeout and tasks
  // ****************************************************
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  // ceiling well above the longest expected run
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      complete_run;
    end
  end
  task tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task do_reset;
    resetn_in = 1'b0;
    tick(2);
    check(oc_enable_out, 1'b0);
    check(auto_addr_en_out, 1'b1);
    resetn_in = 1'b1;
    tick(6);
  endtask
  // held for three debounce windows, so a double count would show
  task press;
    p_err = 4'h0;
    p_code = 4'h0;
    p_rst = 4'h0;
    p_flash = 1'b0;
    service_btn_in = 1'b1;
    for (int k = 0; k < 40; k++) begin
      tick(1);
      p_err = p_err + err_mem_we_out;
      p_code = p_code + code_we_out;
      p_rst = p_rst + restart_out;
      p_flash = p_flash | (leds_out == LEDS_ALL);
      if (k == 3 * DB) service_btn_in = 1'b0;
    end
  endtask
  task dl_byte(input logic [7:0] d, input logic last);
    {dl_stb_in, dl_data_in, dl_last_in} = {1'b1, d, last};
    tick(1);
    got = cfg_we_out;
    {dl_stb_in, dl_data_in, dl_last_in} = {1'b0, ~d, 1'b0};
    tick(2);
  endtask
  task pwd_try(input logic [39:0] p);
    pwd_stb_in = 1'b1;
    pwd_in = p;
    tick(1);
    pwd_stb_in = 1'b0;
    pwd_in = ~p;
    tick(2);
  endtask
  task code_pulse(input logic [31:0] c, input logic others);
    code_stb_in = 1'b1;
    code_in = c;
    others_sending_in = others;
    tick(1);
    code_stb_in = 1'b0;
    code_in = ~c;
    others_sending_in = 1'b0;
    tick(1);
  endtask
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    {service_btn_in, code_stb_in, others_sending_in, fatal_err_in, oc1_off_in} = 5'h00;
    {oc2_off_in, dl_present_in, dl_stb_in, dl_last_in, pwd_stb_in, stop_req_in} = 6'h00;
    {fw_new_mode_in, cfg_valid_in, pwd_chg_stb_in} = 3'h6;
    missing_cnt_in = 6'h01;
    code_in = 32'h0;
    dl_data_in = 8'h00;
    pwd_in = 40'h0;
    user_pwd_in = 40'h0102030405;
    dl_code_in = 16'h1234;
    slave_addr_in = 5'h03;
    do_reset;
    // diagnostics table in protective operation
    for (int i = 0; i < 9; i++) begin
      slave_addr_in = rows[i].a;
      oc1_off_in = rows[i].o1;
      oc2_off_in = rows[i].o2;
      tick(RF + 4);
      master.do_call(rows[i].c, vld, rep);
      check(vld, rows[i].v);
      if (rows[i].v) check(rep, rows[i].r);
    end
    fatal_err_in = 1'b1;
    tick(RF + 4);
    master.do_call(4'h0, vld, rep);
    check({rep, leds_out[LED_FAULT]}, {1'b0, ST_FATAL, 1'b1});
    {oc1_off_in, oc2_off_in, fatal_err_in} = 3'h0;
    dl_byte(8'h5A, 1'b0);
    check(got, 1'b0);
    pwd_try(DEFAULT_PWD);
    check(master_access_out, 1'b0);
    pwd_try(MASTER_SALT ^ {dl_code_in, dl_code_in, dl_code_in[15:8]});
    check(master_access_out, 1'b1);
    stop_req_in = 1'b1;
    tick(2);
    check(stop_out, 1'b1);
    pwd_chg_stb_in = 1'b1;
    tick(1);
    pwd_chg_stb_in = 1'b0;
    check(pwd_we_out, 1'b1);
    stop_req_in = 1'b0;
    // teach one replacement while another one talks
    press;
    check(p_err, 4'h1);
    check(p_flash, 1'b1);
    check(leds_out == LEDS_ALL, 1'b0);
    check(oc_enable_out, 1'b0);
    check(err_one_missing_out, 1'b1);
    check(auto_addr_en_out, 1'b1);
    code_pulse(32'h12345678, 1'b0);
    code_pulse(32'h9ABCDEF1, 1'b1);
    press;
    check(p_code, 4'h1);
    check(code_out, 32'h12345678);
    check(oc_enable_out, 1'b1);
    // two missing, then a code with all nibbles equal
    missing_cnt_in = 6'h02;
    press;
    check(err_one_missing_out, 1'b0);
    check(auto_addr_en_out, 1'b0);
    code_pulse(32'h11111111, 1'b0);
    press;
    check(p_code, 4'h0);
    check(oc_enable_out, 1'b0);
    // newer transfer mode on an empty unit
    cfg_valid_in = 1'b0;
    do_reset;
    check(oc_enable_out, 1'b0);
    master.do_call(4'h0, vld, rep);
    check(rep, {1'b0, ST_CFG_POWERON});
    pwd_try(DEFAULT_PWD);
    check(access_out, 1'b1);
    dl_present_in = 1'b1;
    press;
    check(p_rst, 4'h1);
    check(dl_req_out, 1'b1);
    check(leds_out[LED_READY], 1'b1);
    dl_byte(8'hA5, 1'b0);
    check(got, 1'b1);
    check(cfg_data_out, 8'hA5);
    dl_byte(8'hC3, 1'b1);
    tick(2);
    check({dl_req_out, leds_out[LED_READY]}, 2'h0);
    dl_present_in = 1'b0;
    cfg_valid_in = 1'b1;
    press;
    check(p_rst, 4'h1);
    check(oc_enable_out, 1'b1);
    // older transfer mode copies at power-up
    {fw_new_mode_in, cfg_valid_in, dl_present_in} = 3'h1;
    do_reset;
    check(dl_req_out, 1'b1);
    check(leds_out[LED_READY], 1'b1);
    dl_byte(8'h7E, 1'b1);
    check(got, 1'b1);
    tick(2);
    check(leds_out[1:0], 2'h3);
    complete_run;
  end
endmodule

// >>> rtl/svc_ctrl.sv
// service button, slave teaching, download and password control
// Behaviour
// RULE1: service press enters configuration, outputs off
// RULE2: accepted press flashes all LEDs once
// RULE3: first press records whether exactly one missing
// RULE4: second press captures and checks code sequence
// RULE5: good code stored, back to protection
// RULE6: accept only while other replacements silent
// RULE7: no auto addressing for multiple replacements
// RULE8: download accepted only without valid configuration
// RULE9: old firmware copies automatically at power-up
// RULE10: old mode ready lit, then ready and on
// RULE11: new firmware without configuration enters configuration
// RULE12: new mode press restarts, copies, ready lit
// RULE13: press without cable restarts with new configuration
// RULE14: master password derived from four-digit code
// RULE15: master access allows stop and password change
// RULE16: default password valid until configuration stored
// RULE17: diagnostics only once bus address given
// RULE18: different consecutive calls give different replies
// RULE19: status true and refreshed every 30-150 ms
// RULE20: master asks details only on deviation
// RULE21: alternating calls, same bits, D3 is parity
// RULE22: healthy protection answers zero status bits
// RULE23: one debounced press per button actuation
`timescale 1ns/1ps
module svc_ctrl
  import svc_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC_P = DEBOUNCE_CYC,
  parameter int unsigned LED_FLASH_CYC_P = LED_FLASH_CYC,
  parameter int unsigned REFRESH_CYC_P = STATUS_REFRESH_CYC
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // button and straps
  input wire logic service_btn_in,
  input wire logic fw_new_mode_in,
  input wire logic cfg_valid_in,
  // safe slave bus view
  input wire logic [5:0] missing_cnt_in,
  input wire logic code_stb_in,
  input wire logic [31:0] code_in,
  input wire logic others_sending_in,
  input wire logic fatal_err_in,
  input wire logic oc1_off_in,
  input wire logic oc2_off_in,
  // download link
  input wire logic dl_present_in,
  input wire logic dl_stb_in,
  input wire logic [7:0] dl_data_in,
  input wire logic dl_last_in,
  // password check
  input wire logic pwd_stb_in,
  input wire logic [39:0] pwd_in,
  input wire logic [39:0] user_pwd_in,
  input wire logic [15:0] dl_code_in,
  input wire logic stop_req_in,
  input wire logic pwd_chg_stb_in,
  // diagnostic data calls
  input wire logic [4:0] slave_addr_in,
  input wire logic call_stb_in,
  input wire logic [3:0] call_in,
  output logic [3:0] reply_out,
  output logic reply_vld_out,
  // outputs to the rest of the monitor
  output logic oc_enable_out,
  output logic [3:0] leds_out,
  output logic auto_addr_en_out,
  output logic err_mem_we_out,
  output logic err_one_missing_out,
  output logic code_we_out,
  output logic [31:0] code_out,
  output logic dl_req_out,
  output logic cfg_we_out,
  output logic [7:0] cfg_data_out,
  output logic restart_out,
  output logic access_out,
  output logic master_access_out,
  output logic stop_out,
  output logic pwd_we_out
);

  // ****************************************************
  // helper functions
  // ****************************************************
  // code accepted when no nibble is zero and the lowest nibble differs from the second or from the top one
  function automatic logic code_ok(input logic [31:0] c);
    logic ok;
    ok = (c[3:0] != c[7:4]) || (c[3:0] != c[31:28]);
    for (int i = 0; i < 8; i++) begin
      ok = ok && (c[4*i +: 4] != 4'h0);
    end
    return ok;
  endfunction
  // scrambles the four-digit code into a 40-bit master password
  function automatic logic [39:0] master_pwd(input logic [15:0] code);
    return MASTER_SALT ^ {code, code, code[15:8]};
  endfunction

  // ****************************************************
  // press detection and diagnostics
  // ****************************************************
  logic press;
  logic [2:0] status;
  svc_debounce #(.STABLE_CYC(DEBOUNCE_CYC_P)) u_deb (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .btn_in(service_btn_in),
    .press_out(press)
  );
  svc_diag #(.REFRESH_CYC(REFRESH_CYC_P)) u_diag (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .status_in(status),
    .slave_addr_in(slave_addr_in),
    .call_stb_in(call_stb_in),
    .call_in(call_in),
    .reply_out(reply_out),
    .reply_vld_out(reply_vld_out)
  );

  // ****************************************************
  // operating state machine
  // ****************************************************
  svc_state_t state_r, state_nxt;
  logic [31:0] code_cap_r, code_cap_nxt;
  logic code_seen_r, code_seen_nxt;
  logic auto_addr_r, auto_addr_nxt;
  logic err_we_r, err_we_nxt;
  logic err_one_r, err_one_nxt;
  logic code_we_r, code_we_nxt;
  logic restart_r, restart_nxt;
  logic cfg_we_r, cfg_we_nxt;
  logic [7:0] cfg_data_r, cfg_data_nxt;
  logic [31:0] flash_r, flash_nxt;

  always_comb begin
    state_nxt = state_r;
    code_cap_nxt = code_cap_r;
    code_seen_nxt = code_seen_r;
    auto_addr_nxt = auto_addr_r;
    err_we_nxt = 1'b0;
    err_one_nxt = err_one_r;
    code_we_nxt = 1'b0;
    restart_nxt = 1'b0;
    cfg_we_nxt = 1'b0;
    cfg_data_nxt = cfg_data_r;
    flash_nxt = press ? LED_FLASH_CYC_P : (flash_r != 32'h0) ? flash_r - 32'h1 : 32'h0; // RULE2
    case (state_r)
      S_INIT: begin
        if (!cfg_valid_in && dl_present_in && !fw_new_mode_in) begin
          state_nxt = S_DL_OLD; // RULE9
        end else if (!cfg_valid_in) begin
          state_nxt = S_CFG_POWERON; // RULE11
        end else begin
          state_nxt = S_PROT;
        end
      end
      S_PROT: begin
        if (press) begin
          state_nxt = S_TEACH; // RULE1
          err_we_nxt = 1'b1;
          err_one_nxt = (missing_cnt_in == ONE_MISSING); // RULE3
          auto_addr_nxt = (missing_cnt_in <= ONE_MISSING); // RULE7
          code_seen_nxt = 1'b0;
        end
      end
      S_TEACH: begin
        // a code heard while another replacement still talks is dropped
        if (code_stb_in && !others_sending_in) begin // RULE6
          code_cap_nxt = code_in; // RULE4
          code_seen_nxt = 1'b1;
        end
        if (press) begin
          code_seen_nxt = 1'b0;
          if (code_seen_r && code_ok(code_cap_r)) begin // RULE4
            code_we_nxt = 1'b1;
            state_nxt = S_PROT; // RULE5
          end else begin
            state_nxt = S_CFG; // RULE5
          end
        end
      end
      S_CFG, S_CFG_POWERON: begin
        if (press && dl_present_in && !cfg_valid_in && fw_new_mode_in) begin
          restart_nxt = 1'b1; // RULE12 RULE8
          state_nxt = S_DL_NEW;
        end else if (press && cfg_valid_in) begin
          state_nxt = S_TEACH;
          code_seen_nxt = 1'b0;
        end
      end
      S_DL_OLD, S_DL_NEW: begin
        if (dl_stb_in && !cfg_valid_in) begin // RULE8
          cfg_we_nxt = 1'b1;
          cfg_data_nxt = dl_data_in;
          if (dl_last_in) begin
            state_nxt = (state_r == S_DL_OLD) ? S_DL_OLD_DONE : S_DL_NEW_DONE;
          end
        end
      end
      S_DL_NEW_DONE: begin
        if (press && !dl_present_in) begin
          restart_nxt = 1'b1; // RULE13
          state_nxt = S_PROT;
        end
      end
      S_DL_OLD_DONE: state_nxt = S_DL_OLD_DONE; // terminal until power cycle
      default: state_nxt = S_INIT;
    endcase
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= S_INIT;
      code_cap_r <= 32'h0;
      code_seen_r <= 1'b0;
      auto_addr_r <= 1'b1;
      err_we_r <= 1'b0;
      err_one_r <= 1'b0;
      code_we_r <= 1'b0;
      restart_r <= 1'b0;
      cfg_we_r <= 1'b0;
      cfg_data_r <= 8'h0;
      flash_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      code_cap_r <= code_cap_nxt;
      code_seen_r <= code_seen_nxt;
      auto_addr_r <= auto_addr_nxt;
      err_we_r <= err_we_nxt;
      err_one_r <= err_one_nxt;
      code_we_r <= code_we_nxt;
      restart_r <= restart_nxt;
      cfg_we_r <= cfg_we_nxt;
      cfg_data_r <= cfg_data_nxt;
      flash_r <= flash_nxt;
    end
  end

  // status follows the live state; protection reports circuit states
  always_comb begin
    case (state_r)
      S_PROT: status = {1'b0, oc2_off_in, oc1_off_in}; // RULE22 RULE19
      S_CFG_POWERON, S_INIT: status = ST_CFG_POWERON;
      default: status = ST_CFG;
    endcase
    if (fatal_err_in) begin
      status = ST_FATAL;
    end
  end

  // ****************************************************
  // leds and output circuits
  // ****************************************************
  logic oc_en_r, oc_en_nxt;
  logic [3:0] leds_r, leds_nxt;
  logic dl_req_r, dl_req_nxt;
  always_comb begin
    oc_en_nxt = (state_nxt == S_PROT) && !press; // RULE1
    dl_req_nxt = (state_nxt == S_DL_OLD) || (state_nxt == S_DL_NEW);
    leds_nxt = LEDS_RST;
    leds_nxt[LED_FAULT] = fatal_err_in;
    leds_nxt[LED_OC] = oc_en_nxt;
    leds_nxt[LED_ON] = (state_nxt == S_PROT) || (state_nxt == S_DL_OLD_DONE); // RULE10
    case (state_nxt)
      S_DL_OLD, S_DL_NEW, S_DL_OLD_DONE: leds_nxt[LED_READY] = 1'b1; // RULE10 RULE12
      default: leds_nxt[LED_READY] = 1'b0; // RULE12
    endcase
    if (flash_nxt != 32'h0) begin
      leds_nxt = LEDS_ALL; // RULE2
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      oc_en_r <= 1'b0;
      leds_r <= LEDS_RST;
      dl_req_r <= 1'b0;
    end else begin
      oc_en_r <= oc_en_nxt;
      leds_r <= leds_nxt;
      dl_req_r <= dl_req_nxt;
    end
  end

  // ****************************************************
  // password access
  // ****************************************************
  logic access_r, access_nxt;
  logic master_r, master_nxt;
  logic stop_r, stop_nxt;
  logic pwd_we_r, pwd_we_nxt;
  // a new check replaces the previous grant, master access included; stop is sticky
  always_comb begin
    access_nxt = access_r;
    master_nxt = master_r;
    stop_nxt = stop_r || (master_r && stop_req_in); // RULE15
    pwd_we_nxt = master_r && pwd_chg_stb_in; // RULE15
    if (pwd_stb_in) begin
      master_nxt = (pwd_in == master_pwd(dl_code_in)) && cfg_valid_in; // RULE14
      access_nxt = (pwd_in == user_pwd_in) || master_nxt
        || (!cfg_valid_in && pwd_in == DEFAULT_PWD); // RULE16
    end
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      access_r <= 1'b0;
      master_r <= 1'b0;
      stop_r <= 1'b0;
      pwd_we_r <= 1'b0;
    end else begin
      access_r <= access_nxt;
      master_r <= master_nxt;
      stop_r <= stop_nxt;
      pwd_we_r <= pwd_we_nxt;
    end
  end

  // ****************************************************
  // output wiring, every one from a flip-flop
  // ****************************************************
  assign oc_enable_out = oc_en_r;
  assign leds_out = leds_r;
  assign auto_addr_en_out = auto_addr_r;
  assign err_mem_we_out = err_we_r;
  assign err_one_missing_out = err_one_r;
  assign code_we_out = code_we_r;
  assign code_out = code_cap_r;
  assign dl_req_out = dl_req_r;
  assign cfg_we_out = cfg_we_r;
  assign cfg_data_out = cfg_data_r;
  assign restart_out = restart_r;
  assign access_out = access_r;
  assign master_access_out = master_r;
  assign stop_out = stop_r;
  assign pwd_we_out = pwd_we_r;
endmodule

// >>> rtl/svc_debounce.sv
// service button debouncer producing one pulse per press
`timescale 1ns/1ps
module svc_debounce
  import svc_pkg::*;
#(
  parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // button and press event
  input wire logic btn_in,
  output logic press_out
);

  logic level_r, level_nxt;
  logic press_r, press_nxt;
  logic [31:0] cnt_r, cnt_nxt;

  // a level change must hold for the whole window; bounce restarts it
  always_comb begin
    level_nxt = level_r;
    press_nxt = 1'b0;
    cnt_nxt = 32'h0;
    if (btn_in != level_r) begin
      if (cnt_r >= STABLE_CYC - 1) begin
        level_nxt = btn_in;
        press_nxt = btn_in; // RULE23
      end else begin
        cnt_nxt = cnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      level_r <= 1'b0;
      press_r <= 1'b0;
      cnt_r <= 32'h0;
    end else begin
      level_r <= level_nxt;
      press_r <= press_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign press_out = press_r;

endmodule

// >>> rtl/svc_diag.sv
// answers the alternating basic data calls from the bus master
`timescale 1ns/1ps
module svc_diag
  import svc_pkg::*;
#(
  parameter int unsigned REFRESH_CYC = STATUS_REFRESH_CYC
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // live status and own bus address
  input wire logic [2:0] status_in,
  input wire logic [4:0] slave_addr_in,
  // data call and reply
  input wire logic call_stb_in,
  input wire logic [3:0] call_in,
  output logic [3:0] reply_out,
  output logic reply_vld_out
);

  logic [2:0] snap_r, snap_nxt;
  logic [2:0] held_r, held_nxt;
  logic last_odd_r, last_odd_nxt;
  logic [3:0] reply_r, reply_nxt;
  logic vld_r, vld_nxt;
  logic [31:0] tick_r, tick_nxt;

  // the snapshot is refreshed on a fixed period so a slow master still
  // sees a coherent state; the odd call freezes it until the next even call
  always_comb begin
    snap_nxt = snap_r;
    held_nxt = held_r;
    last_odd_nxt = last_odd_r;
    reply_nxt = reply_r;
    vld_nxt = 1'b0;
    tick_nxt = tick_r + 32'h1;
    if (tick_r >= REFRESH_CYC - 1) begin
      tick_nxt = 32'h0;
      snap_nxt = status_in; // RULE19
    end
    if (call_stb_in && slave_addr_in != NO_ADDR) begin // RULE17
      if (call_in == CALL_EVEN) begin
        vld_nxt = 1'b1;
        last_odd_nxt = 1'b0;
        reply_nxt = {1'b0, snap_r}; // RULE21 RULE22
      end else if (call_in == CALL_ODD) begin
        vld_nxt = 1'b1;
        last_odd_nxt = 1'b1;
        if (!last_odd_r) begin
          held_nxt = snap_r;
          reply_nxt = {1'b1, snap_r}; // RULE21 RULE18
        end else begin
          reply_nxt = {1'b1, held_r};
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      snap_r <= ST_CFG_POWERON;
      held_r <= ST_CFG_POWERON;
      last_odd_r <= 1'b0;
      reply_r <= 4'h0;
      vld_r <= 1'b0;
      tick_r <= 32'h0;
    end else begin
      snap_r <= snap_nxt;
      held_r <= held_nxt;
      last_odd_r <= last_odd_nxt;
      reply_r <= reply_nxt;
      vld_r <= vld_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign reply_out = reply_r;
  assign reply_vld_out = vld_r;

endmodule

// >>> rtl/svc_pkg.sv
// constants and types shared by the safety monitor service logic
package svc_pkg;

  // ****************************************************
  // clock and timing
  // ****************************************************
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
  localparam int unsigned LED_FLASH_MS = 250;
  localparam int unsigned LED_FLASH_CYC = LED_FLASH_MS * CLK_KHZ;
  localparam int unsigned STATUS_REFRESH_MS = 50;
  localparam int unsigned STATUS_REFRESH_CYC = STATUS_REFRESH_MS * CLK_KHZ;

  // ****************************************************
  // passwords and codes
  // ****************************************************
  localparam logic [39:0] DEFAULT_PWD = 40'h53494D4F4E;
  localparam logic [39:0] MASTER_SALT = 40'h5A3C96A5C3;
  localparam logic [5:0] ONE_MISSING = 6'h01;
  localparam logic [4:0] NO_ADDR = 5'h00;

  // ****************************************************
  // status codes and call codes of the basic data calls
  // ****************************************************
  localparam logic [2:0] ST_CFG_POWERON = 3'h4;
  localparam logic [2:0] ST_CFG = 3'h5;
  localparam logic [2:0] ST_FATAL = 3'h7;
  localparam logic [3:0] CALL_EVEN = 4'h0;
  localparam logic [3:0] CALL_ODD = 4'h1;

  // ****************************************************
  // led bit positions, reset and flash values
  // ****************************************************
  localparam int unsigned LED_READY = 0;
  localparam int unsigned LED_ON = 1;
  localparam int unsigned LED_FAULT = 2;
  localparam int unsigned LED_OC = 3;
  localparam logic [3:0] LEDS_RST = 4'h0;
  localparam logic [3:0] LEDS_ALL = 4'hF;

  typedef enum logic [3:0] {
    S_INIT, S_PROT, S_CFG_POWERON, S_CFG, S_TEACH, S_DL_OLD, S_DL_OLD_DONE,
    S_DL_NEW, S_DL_NEW_DONE
  } svc_state_t;

endpackage
